// file: rtl/spc_evt_if.sv
// carrier between the register file and the event qualifier
`timescale 1ns/1ps
`default_nettype none

interface spc_evt_if;
  import spc_pkg::*;
  spc_mode_t mode; // current serial mode
  logic multiproc; // multiprocessor enable
  logic rx_done; // engine finished a character
  logic rx_ninth; // received ninth data bit
  logic rx_stop; // sampled stop bit level
  logic tx_bit8_end; // end of eighth bit time
  logic tx_stop_start; // start of stop bit
  logic set_rx_irq; // qualified receive flag set
  logic set_tx_irq; // qualified transmit flag set
  logic set_frame_err; // qualified framing error set
  logic cap_ninth_rx; // load the ninth received bit
  logic ninth_rx_val; // value to load

  // register side drives the raw events
  modport regs (
    output mode, multiproc, rx_done, rx_ninth, rx_stop,
    output tx_bit8_end, tx_stop_start,
    input set_rx_irq, set_tx_irq, set_frame_err,
    input cap_ninth_rx, ninth_rx_val
  );
  // qualifier turns raw events into flag updates
  modport qual (
    input mode, multiproc, rx_done, rx_ninth, rx_stop,
    input tx_bit8_end, tx_stop_start,
    output set_rx_irq, set_tx_irq, set_frame_err,
    output cap_ninth_rx, ninth_rx_val
  );
endinterface

`default_nettype wire

// file: rtl/spc_evt_qual.sv
// qualifies shifting engine events by serial mode
`timescale 1ns/1ps
`default_nettype none

module spc_evt_qual
  import spc_pkg::*;
(
  // event carrier
  spc_evt_if.qual evt
);

  // pure combinational decode, flags live in the register file
  always_comb begin
    evt.set_rx_irq = 1'b0;
    evt.set_tx_irq = 1'b0;
    evt.set_frame_err = 1'b0;
    evt.cap_ninth_rx = 1'b0;
    evt.ninth_rx_val = 1'b0;
    case (evt.mode)
      // shift register mode: no stop bit, ninth bit unused
      SPC_MODE_SHIFT: begin
        evt.set_tx_irq = evt.tx_bit8_end; // [RULE_08]
        evt.set_rx_irq = evt.rx_done;
      end
      // 8-bit asynchronous mode
      SPC_MODE_8BIT: begin
        evt.set_tx_irq = evt.tx_stop_start; // [RULE_08]
        // with multiproc set a bad stop bit suppresses the flag
        evt.set_rx_irq = evt.rx_done & (~evt.multiproc | evt.rx_stop);
        evt.cap_ninth_rx = evt.rx_done & ~evt.multiproc; // [RULE_09]
        evt.ninth_rx_val = evt.rx_stop; // [RULE_09]
        evt.set_frame_err = evt.rx_done & ~evt.rx_stop; // [RULE_02]
      end
      // both 9-bit modes behave alike here
      default: begin
        evt.set_tx_irq = evt.tx_stop_start; // [RULE_08]
        // address filtering on the ninth bit
        evt.set_rx_irq = evt.rx_done & (~evt.multiproc | evt.rx_ninth);
        evt.cap_ninth_rx = evt.rx_done; // [RULE_09]
        evt.ninth_rx_val = evt.rx_ninth; // [RULE_09]
        evt.set_frame_err = evt.rx_done & ~evt.rx_stop; // [RULE_02]
      end
    endcase
  end

endmodule

`default_nettype wire

// file: rtl/spc_params.svh
// constants for the serial port control and status register block
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH

// register location and reset value
`define SPC_CTRL_ADDR 8'h98
`define SPC_CTRL_RESET 8'h00
// bit-addressable window: bits 0..7 sit at 98h..9Fh
`define SPC_BIT_BASE 5'h13

// field positions inside the register
`define SPC_BIT_MODE_HIGH 7
`define SPC_BIT_MODE_LOW 6
`define SPC_BIT_MULTIPROC 5
`define SPC_BIT_RX_ENABLE 4
`define SPC_BIT_NINTH_TX 3
`define SPC_BIT_NINTH_RX 2
`define SPC_BIT_TX_IRQ 1
`define SPC_BIT_RX_IRQ 0

// fixed rate divisors of the cpu clock; zero means timer driven
`define SPC_DIV_SHIFT 8'h06
`define SPC_DIV_SLOW 8'h20
`define SPC_DIV_FAST 8'h10
`define SPC_DIV_TIMER 8'h00

`endif

// file: rtl/spc_pkg.sv
// types shared by the serial port control block
package spc_pkg;

  // serial mode as chosen by the two mode-select bits
  typedef enum logic [1:0] {
    SPC_MODE_SHIFT = 2'h0,
    SPC_MODE_8BIT = 2'h1,
    SPC_MODE_9BIT_FIXED = 2'h2,
    SPC_MODE_9BIT_VAR = 2'h3
  } spc_mode_t;

endpackage

// file: rtl/spc_serial_ctrl.sv
// serial port control and status register with framing error view
`timescale 1ns/1ps
`default_nettype none
`include "spc_params.svh"

// Operation
// [RULE_01] top bit shows mode-high or framing error
// [RULE_02] bad stop bit sets framing error
// [RULE_03] framing error sticky until software clears
// [RULE_04] mode bits; 00 is shift, clock/6
// [RULE_05] register holds ninth bits and flags
// [RULE_06] address 98h, bit addressable, resets 00h
// [RULE_07] 01 8-bit variable; 10,11 9-bit modes
// [RULE_08] tx flag timing per mode, software clears
// [RULE_09] ninth rx bit capture per mode
// [RULE_10] multiproc blocks rx flag on ninth zero
// [RULE_11] error view writes leave mode-high intact
module spc_serial_ctrl
  import spc_pkg::*;
(
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // special function register byte access
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  // bit access
  input wire logic [7:0] bit_addr_i,
  input wire logic bit_wr_i,
  input wire logic bit_val_i,
  // power control bits held elsewhere
  input wire logic frame_error_select_i,
  input wire logic rate_double_select_i,
  // shifting engine events
  input wire logic rx_done_i,
  input wire logic rx_ninth_i,
  input wire logic rx_stop_i,
  input wire logic tx_bit8_end_i,
  input wire logic tx_stop_start_i,
  // control outputs to the engines
  output logic [1:0] mode_o,
  output logic multiproc_enable_o,
  output logic rx_enable_o,
  output logic ninth_tx_bit_o,
  output logic ninth_rx_bit_o,
  output logic tx_irq_flag_o,
  output logic rx_irq_flag_o,
  output logic framing_error_flag_o,
  output logic [7:0] baud_div_o
);

  spc_evt_if evt(); // event carrier to the qualifier

  logic mode_select_high_reg; // stored upper mode bit
  logic mode_select_low_reg; // lower mode bit
  logic multiproc_enable_reg; // address filtering enable
  logic rx_enable_reg; // reception enable
  logic ninth_tx_bit_reg; // ninth bit to send
  logic ninth_rx_bit_reg; // ninth bit received
  logic tx_irq_flag_reg; // transmit done flag
  logic rx_irq_flag_reg; // receive done flag
  logic framing_error_flag_reg; // sticky stop bit error
  logic [7:0] rdata_reg; // registered read data
  logic [7:0] baud_div_reg; // fixed divisor or timer marker
  logic [7:0] ctrl_view; // register as software sees it
  logic [7:0] wr_mask; // bits being written this cycle
  logic [7:0] wr_val; // values for those bits
  logic byte_hit; // byte write to our address
  logic bit_hit; // bit write into our window

  assign evt.mode = spc_mode_t'({mode_select_high_reg,
                                 mode_select_low_reg}); // [RULE_04]
  assign evt.multiproc = multiproc_enable_reg;
  assign evt.rx_done = rx_done_i;
  assign evt.rx_ninth = rx_ninth_i;
  assign evt.rx_stop = rx_stop_i;
  assign evt.tx_bit8_end = tx_bit8_end_i;
  assign evt.tx_stop_start = tx_stop_start_i;

  // event qualifier
  spc_evt_qual u_qual (
    .evt(evt.qual)
  );

  // register view, top bit chosen by the power control select
  always_comb begin
    ctrl_view = {
      frame_error_select_i ? framing_error_flag_reg
                           : mode_select_high_reg, // [RULE_01]
      mode_select_low_reg,
      multiproc_enable_reg,
      rx_enable_reg,
      ninth_tx_bit_reg,
      ninth_rx_bit_reg,
      tx_irq_flag_reg,
      rx_irq_flag_reg
    }; // [RULE_05]
  end

  // address decode for byte and bit writes
  always_comb begin
    byte_hit = sfr_wr_i && (sfr_addr_i == `SPC_CTRL_ADDR); // [RULE_06]
    bit_hit = bit_wr_i && (bit_addr_i[7:3] == `SPC_BIT_BASE); // [RULE_06]
    wr_mask = 8'h00;
    wr_val = 8'h00;
    if (byte_hit) begin
      wr_mask = 8'hFF;
      wr_val = sfr_wdata_i;
    end else if (bit_hit) begin
      // single bit, others untouched
      wr_mask = 8'h01 << bit_addr_i[2:0];
      wr_val = {8{bit_val_i}};
    end
  end

  // plain software bits
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mode_select_low_reg <= 1'b0;
      multiproc_enable_reg <= 1'b0;
      rx_enable_reg <= 1'b0;
      ninth_tx_bit_reg <= 1'b0;
    end else if (ce_i) begin
      if (wr_mask[`SPC_BIT_MODE_LOW])
        mode_select_low_reg <= wr_val[`SPC_BIT_MODE_LOW];
      if (wr_mask[`SPC_BIT_MULTIPROC])
        multiproc_enable_reg <= wr_val[`SPC_BIT_MULTIPROC];
      if (wr_mask[`SPC_BIT_RX_ENABLE])
        rx_enable_reg <= wr_val[`SPC_BIT_RX_ENABLE];
      if (wr_mask[`SPC_BIT_NINTH_TX])
        ninth_tx_bit_reg <= wr_val[`SPC_BIT_NINTH_TX];
    end
  end

  // shared top bit: writes land on whichever field is in view
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mode_select_high_reg <= 1'b0;
    end else if (ce_i) begin
      // held while the error view is selected
      if (wr_mask[`SPC_BIT_MODE_HIGH] && !frame_error_select_i)
        mode_select_high_reg <= wr_val[`SPC_BIT_MODE_HIGH]; // [RULE_11]
    end
  end

  // sticky framing error; a new error beats a clearing write
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      framing_error_flag_reg <= 1'b0;
    end else if (ce_i) begin
      if (evt.set_frame_err)
        framing_error_flag_reg <= 1'b1; // [RULE_02]
      else if (wr_mask[`SPC_BIT_MODE_HIGH] && frame_error_select_i)
        framing_error_flag_reg <= wr_val[`SPC_BIT_MODE_HIGH]; // [RULE_03]
    end
  end

  // ninth received bit, loaded by hardware, writable by software
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ninth_rx_bit_reg <= 1'b0;
    end else if (ce_i) begin
      if (evt.cap_ninth_rx)
        ninth_rx_bit_reg <= evt.ninth_rx_val; // [RULE_09]
      else if (wr_mask[`SPC_BIT_NINTH_RX])
        ninth_rx_bit_reg <= wr_val[`SPC_BIT_NINTH_RX];
    end
  end

  // transmit flag, set wins over a clearing write
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tx_irq_flag_reg <= 1'b0;
    end else if (ce_i) begin
      if (evt.set_tx_irq)
        tx_irq_flag_reg <= 1'b1; // [RULE_08]
      else if (wr_mask[`SPC_BIT_TX_IRQ])
        tx_irq_flag_reg <= wr_val[`SPC_BIT_TX_IRQ]; // [RULE_08]
    end
  end

  // receive flag, qualified by multiproc filtering
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rx_irq_flag_reg <= 1'b0;
    end else if (ce_i) begin
      if (evt.set_rx_irq)
        rx_irq_flag_reg <= 1'b1; // [RULE_10]
      else if (wr_mask[`SPC_BIT_RX_IRQ])
        rx_irq_flag_reg <= wr_val[`SPC_BIT_RX_IRQ];
    end
  end

  // registered read port, unmapped addresses read zero
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_reg <= `SPC_CTRL_RESET;
    end else if (ce_i) begin
      if (sfr_rd_i && (sfr_addr_i == `SPC_CTRL_ADDR))
        rdata_reg <= ctrl_view; // [RULE_01]
      else
        rdata_reg <= 8'h00;
    end
  end

  // rate divisor follows the mode; timer modes report zero
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      baud_div_reg <= `SPC_DIV_SHIFT;
    end else if (ce_i) begin
      case (evt.mode)
        SPC_MODE_SHIFT: baud_div_reg <= `SPC_DIV_SHIFT; // [RULE_04]
        SPC_MODE_9BIT_FIXED: begin
          // double rate select halves the divisor
          baud_div_reg <= rate_double_select_i ? `SPC_DIV_FAST
                                               : `SPC_DIV_SLOW; // [RULE_07]
        end
        default: baud_div_reg <= `SPC_DIV_TIMER; // [RULE_07]
      endcase
    end
  end

  // outputs straight from flops
  assign sfr_rdata_o = rdata_reg;
  assign mode_o = {mode_select_high_reg, mode_select_low_reg};
  assign multiproc_enable_o = multiproc_enable_reg;
  assign rx_enable_o = rx_enable_reg;
  assign ninth_tx_bit_o = ninth_tx_bit_reg;
  assign ninth_rx_bit_o = ninth_rx_bit_reg;
  assign tx_irq_flag_o = tx_irq_flag_reg;
  assign rx_irq_flag_o = rx_irq_flag_reg;
  assign framing_error_flag_o = framing_error_flag_reg;
  assign baud_div_o = baud_div_reg;

endmodule

`default_nettype wire

// file: verif/spc_engine_model.sv
// behavioural shifting engine that feeds character events to the block
`timescale 1ns/1ps
`default_nettype none

module spc_engine_model (
  // clock
  input wire logic mclk_i,
  // events toward the register block
  output logic rx_done_o,
  output logic rx_ninth_o,
  output logic rx_stop_o,
  output logic tx_bit8_end_o,
  output logic tx_stop_start_o
);
  // idle: no events pending
  initial begin
    rx_done_o = 1'b0;
    rx_ninth_o = 1'b0;
    rx_stop_o = 1'b1;
    tx_bit8_end_o = 1'b0;
    tx_stop_start_o = 1'b0;
  end
  // one received character; data lines inverted afterwards so that
  // nothing can lean on a stale level outside the event
  task automatic rx_char(input logic ninth, input logic stop);
    @(negedge mclk_i);
    rx_done_o = 1'b1;
    rx_ninth_o = ninth;
    rx_stop_o = stop;
    @(negedge mclk_i);
    rx_done_o = 1'b0;
    rx_ninth_o = ~ninth;
    rx_stop_o = ~stop;
  endtask
  // transmit timing pulse: bit-eight end or stop-bit start
  task automatic tx_event(input logic stop_phase);
    @(negedge mclk_i);
    tx_bit8_end_o = ~stop_phase;
    tx_stop_start_o = stop_phase;
    @(negedge mclk_i);
    tx_bit8_end_o = 1'b0;
    tx_stop_start_o = 1'b0;
  endtask
endmodule

`default_nettype wire

// file: verif/spc_serial_ctrl_sva.sv
// assertions on the serial control register block ports
`timescale 1ns/1ps
`default_nettype none

module spc_serial_ctrl_sva
  import spc_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // register access
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic [7:0] bit_addr_i,
  input wire logic bit_wr_i,
  // power control levels
  input wire logic frame_error_select_i,
  input wire logic rate_double_select_i,
  // engine events
  input wire logic rx_done_i,
  input wire logic rx_ninth_i,
  input wire logic rx_stop_i,
  input wire logic tx_bit8_end_i,
  input wire logic tx_stop_start_i,
  // register outputs
  input wire logic [1:0] mode_o,
  input wire logic multiproc_enable_o,
  input wire logic ninth_rx_bit_o,
  input wire logic tx_irq_flag_o,
  input wire logic rx_irq_flag_o,
  input wire logic framing_error_flag_o,
  input wire logic [7:0] baud_div_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic byte_wr; // byte write to the register
  logic top_wr; // bit write to the shared top bit
  logic low_wr; // bit write to the receive flag
  assign byte_wr = sfr_wr_i && (sfr_addr_i == 8'h98);
  assign top_wr = bit_wr_i && (bit_addr_i == 8'h9F);
  assign low_wr = bit_wr_i && (bit_addr_i == 8'h98);
  // divisor per mode; zero stands for the timer-driven rate
  function automatic logic [7:0] exp_div(input logic [1:0] m, input logic r);
    if (m == 2'h0) return 8'h06;
    if (m == 2'h2) return r ? 8'h10 : 8'h20;
    return 8'h00;
  endfunction
  // quiet reads only, so the view is not muddied by a same-cycle update
  top_view_a: assert property (
    ce_i && sfr_rd_i && sfr_addr_i == 8'h98 && !sfr_wr_i && !bit_wr_i &&
    !rx_done_i |=> sfr_rdata_o[7] ==
    $past(frame_error_select_i ? framing_error_flag_o : mode_o[1]))
    else $error("top bit view wrong");
  fe_set_a: assert property (
    ce_i && rx_done_i && !rx_stop_i && mode_o != 2'h0 |=>
    framing_error_flag_o)
    else $error("framing error not set");
  fe_sticky_a: assert property (
    framing_error_flag_o && !byte_wr && !top_wr |=> framing_error_flag_o)
    else $error("framing error lost");
  baud_map_a: assert property (
    ce_i |=> baud_div_o ==
    exp_div($past(mode_o), $past(rate_double_select_i)))
    else $error("divisor wrong for mode");
  mode_keep_a: assert property (
    ce_i && frame_error_select_i && (byte_wr || top_wr) |=>
    $stable(mode_o[1]))
    else $error("mode high changed");
  tx_flag_a: assert property (
    ce_i && ((mode_o == 2'h0 && tx_bit8_end_i) ||
    (mode_o != 2'h0 && tx_stop_start_i)) |=> tx_irq_flag_o)
    else $error("tx flag not set");
  ninth_cap_a: assert property (
    ce_i && mode_o[1] && rx_done_i |=> ninth_rx_bit_o == $past(rx_ninth_i))
    else $error("ninth bit not captured");
  rx_block_a: assert property (
    ce_i && mode_o[1] && multiproc_enable_o && rx_done_i && !rx_ninth_i &&
    !rx_irq_flag_o && !byte_wr && !low_wr |=> !rx_irq_flag_o)
    else $error("rx flag raised");
  // a low enable freezes mode, flags and divisor, read data included
  ce_hold_a: assert property (
    !ce_i |=> $stable(mode_o) && $stable(framing_error_flag_o) &&
    $stable(tx_irq_flag_o) && $stable(rx_irq_flag_o) &&
    $stable(sfr_rdata_o) && $stable(baud_div_o))
    else $error("state moved while enable low");
  // main scenarios
  view_c: cover property (
    sfr_rd_i && sfr_addr_i == 8'h98 && frame_error_select_i);
  fe_c: cover property ($rose(framing_error_flag_o));
  block_c: cover property (multiproc_enable_o && rx_done_i && !rx_ninth_i);
  hold_c: cover property (!ce_i && rx_done_i);
endmodule

bind spc_serial_ctrl spc_serial_ctrl_sva chk_u (.*);

`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for the serial control and status register
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import spc_pkg::*;
  logic mclk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1; // enable high, dropped once for the freeze test
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, bit_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, bit_wr_i = 1'b0, bit_val_i = 1'b0;
  logic frame_error_select_i = 1'b0, rate_double_select_i = 1'b0;
  logic rx_done_i, rx_ninth_i, rx_stop_i, tx_bit8_end_i, tx_stop_start_i;
  logic [7:0] sfr_rdata_o, baud_div_o, exp;
  logic [1:0] mode_o;
  logic multiproc_enable_o, rx_enable_o, ninth_tx_bit_o, ninth_rx_bit_o;
  logic tx_irq_flag_o, rx_irq_flag_o, framing_error_flag_o;
  int n_mismatch = 0, comparisons = 0;

  spc_serial_ctrl dut_u (.*);
  spc_engine_model pm_u (.mclk_i(mclk_i), .rx_done_o(rx_done_i),
    .rx_ninth_o(rx_ninth_i), .rx_stop_o(rx_stop_i),
    .tx_bit8_end_o(tx_bit8_end_i), .tx_stop_start_o(tx_stop_start_i));

  // 100 MHz core clock
  always #5 mclk_i = ~mclk_i;
  // packed status: error, mode, multiproc, ninth tx/rx, tx/rx flags
  function automatic logic [7:0] st();
    return {framing_error_flag_o, mode_o, multiproc_enable_o,
      ninth_tx_bit_o, ninth_rx_bit_o, tx_irq_flag_o, rx_irq_flag_o};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    comparisons++;
    if (got !== want) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, want);
    end
  endtask
  // byte write, strobe held for exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge mclk_i);
    sfr_wr_i = 1'b0;
  endtask
  // read data stands one cycle only, so it is checked right then
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    @(negedge mclk_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge mclk_i);
    sfr_rd_i = 1'b0;
    chk(sfr_rdata_o, want);
  endtask
  task automatic bw(input logic [2:0] n, input logic v);
    @(negedge mclk_i);
    bit_addr_i = {5'h13, n};
    bit_val_i = v;
    bit_wr_i = 1'b1;
    @(negedge mclk_i);
    bit_wr_i = 1'b0;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watchdog far beyond the hundred or so cycles the tests take
  initial begin
    #20000;
    n_mismatch++;
    results();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    reset_i = 1'b0;
    rd(8'h98, 8'h00);
    rd(8'h99, 8'h00);
    chk(baud_div_o, 8'h06);
    // every mode with both mode-2 rate settings
    for (int m = 0; m < 4; m++) begin
      for (int r = 0; r < 2; r++) begin
        rate_double_select_i = r[0];
        wr(8'h98, {m[1:0], 6'h00});
        @(negedge mclk_i);
        exp = (m == 0) ? 8'h06 : (m == 2) ? (r ? 8'h10 : 8'h20) : 8'h00;
        chk(baud_div_o, exp);
        chk({6'h00, mode_o}, 8'(m));
      end
    end
    wr(8'h98, 8'h4E);
    chk(st(), 8'h2E);
    rd(8'h98, 8'h4E);
    // bad stop in 8-bit mode, then a good character
    wr(8'h98, 8'h40);
    pm_u.rx_char(1'b1, 1'b0);
    chk(st(), 8'hA1);
    pm_u.rx_char(1'b0, 1'b1);
    chk(st(), 8'hA5);
    frame_error_select_i = 1'b1;
    rd(8'h98, 8'hC5);
    frame_error_select_i = 1'b0;
    rd(8'h98, 8'h45);
    // error view: top bit writes leave mode high alone
    frame_error_select_i = 1'b1;
    wr(8'h98, 8'hC0);
    chk(st(), 8'hA0);
    bw(3'h7, 1'b0);
    chk(st(), 8'h20);
    frame_error_select_i = 1'b0;
    bw(3'h7, 1'b1);
    chk(st(), 8'h60);
    // multiprocessor filter in 9-bit mode
    wr(8'h98, 8'hE0);
    pm_u.rx_char(1'b0, 1'b1);
    chk(st(), 8'h70);
    pm_u.rx_char(1'b1, 1'b1);
    chk(st(), 8'h75);
    // transmit flag timing; shift mode ignores stop bits
    wr(8'h98, 8'h00);
    pm_u.tx_event(1'b0);
    chk(st(), 8'h02);
    pm_u.rx_char(1'b0, 1'b0);
    chk(st(), 8'h03);
    wr(8'h98, 8'h40);
    pm_u.tx_event(1'b1);
    chk(st(), 8'h22);
    wr(8'h99, 8'hFF);
    chk(st(), 8'h22);
    // enable low freezes writes and engine events alike
    ce_i = 1'b0;
    wr(8'h98, 8'h10);
    pm_u.rx_char(1'b0, 1'b0);
    chk(st(), 8'h22);
    ce_i = 1'b1;
    // mode 1 with multiproc: bad stop keeps rx flag and ninth bit
    wr(8'h98, 8'h64);
    pm_u.rx_char(1'b0, 1'b0);
    chk(st(), 8'hB4);
    // error view: clearing write, reception enable set
    frame_error_select_i = 1'b1;
    wr(8'h98, 8'h10);
    chk(st(), 8'h00);
    chk({7'h00, rx_enable_o}, 8'h01);
    rd(8'h98, 8'h10);
    frame_error_select_i = 1'b0;
    wr(8'h98, 8'hD0);
    // mid-run reset returns every field to its reset value
    @(negedge mclk_i);
    reset_i = 1'b1;
    @(negedge mclk_i);
    reset_i = 1'b0;
    chk(st(), 8'h00);
    chk({7'h00, rx_enable_o}, 8'h00);
    chk(baud_div_o, 8'h06);
    rd(8'h98, 8'h00);
    results();
  end
endmodule

`default_nettype wire
